// ---- rtl/hfq_fifo.sv ----
// Byte queue with selectable capacity, valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none

module hfq_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 512,
  parameter int CW    = 10
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             reset_i,
  // Control
  input  wire logic             flush_i,
  input  wire logic [CW-1:0]    cap_i,
  // Fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o,
  // Level
  output logic [CW-1:0]         count_o
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wptr_r;
  logic [AW-1:0]    rptr_r;
  logic [CW-1:0]    count_r;
  logic             push;
  logic             pop;

  // Full is judged against the selected capacity, not the array size
  assign in_ready_o  = (count_r < cap_i);
  assign out_valid_o = (count_r != '0);
  assign push        = in_valid_i && in_ready_o && !flush_i;
  assign pop         = out_valid_o && out_ready_i && !flush_i;
  assign out_data_o  = mem_r[rptr_r];
  assign count_o     = count_r;

  // Storage array
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_r[wptr_r] <= in_data_i;
    end
  end

  // Pointers and level; flush wins over traffic
  always_ff @(posedge clk_i) begin
    if (reset_i || flush_i) begin
      wptr_r  <= '0;
      rptr_r  <= '0;
      count_r <= '0;
    end else begin
      if (push) wptr_r <= wptr_r + AW'(1);
      if (pop)  rptr_r <= rptr_r + AW'(1);
      count_r <= count_r + CW'(push) - CW'(pop);
    end
  end

endmodule : hfq_fifo

`default_nettype wire

// ---- rtl/hfq_params.svh ----
// Register map, field positions and sizes of the host queue and interrupt block
`ifndef HFQ_PARAMS_SVH
`define HFQ_PARAMS_SVH

// Register addresses (byte index on the host register port)
`define HFQ_ADDR_CTRL      7'h02
`define HFQ_ADDR_THRESH    7'h03
`define HFQ_ADDR_FILL      7'h04
`define HFQ_ADDR_PORT      7'h05
`define HFQ_ADDR_STAT_A    7'h06
`define HFQ_ADDR_STAT_B    7'h07
`define HFQ_ADDR_MASK_A    7'h08
`define HFQ_ADDR_MASK_B    7'h09

// Queue control fields
`define HFQ_CTRL_SIZE_BIT  7
`define HFQ_CTRL_HIGH_BIT  6
`define HFQ_CTRL_LOW_BIT   5
`define HFQ_CTRL_FLUSH_BIT 4
`define HFQ_CTRL_THR8_BIT  2

// Capacities
`define HFQ_CAP_SMALL      10'h0ff
`define HFQ_CAP_LARGE      10'h200

// Interrupt register fields
`define HFQ_SETCLR_BIT     7
`define HFQ_ANY_BIT        6
`define HFQ_STAT_B_MASK    6'h3f
`define HFQ_INV_BIT        7
`define HFQ_PIN_GATE_BIT   6
`define HFQ_PUSH_PULL_BIT  7

// Reset values
`define HFQ_RST_BYTE       8'h00
`define HFQ_RST_CTRL       8'h00

`endif

// ---- rtl/hfq_pkg.sv ----
// Types shared by the host queue and interrupt block
package hfq_pkg;

  // Host link type selected outside this block
  typedef enum logic [1:0] {
    HFQ_LINK_UART = 2'b00,
    HFQ_LINK_SPI  = 2'b01,
    HFQ_LINK_I2C  = 2'b10
  } hfq_link_e;

  // One host register access
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [6:0] addr;
    logic [7:0] wdata;
  } hfq_req_s;

  // Events from the command, transceiver, timer and detection engines
  typedef struct packed {
    logic       cmd_self_idle;
    logic       send_done;
    logic       recv_end;
    logic       frame_start;
    logic       queue_write_fault;
    logic       protocol_fault;
    logic       empty_send_fault;
    logic       integrity_fault;
    logic [4:0] tmr_underflow;
    logic       card_detect;
  } hfq_evt_s;

endpackage : hfq_pkg

// ---- rtl/hfq_stage.sv ----
// Eight-word output buffer between the queue and the host read port
`timescale 1ns/1ps
`default_nettype none

module hfq_stage #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             reset_i,
  input  wire logic             flush_i,
  // Fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o,
  // Level
  output logic [$clog2(DEPTH):0] count_o
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wptr_r;
  logic [AW-1:0]    rptr_r;
  logic [AW:0]      count_r;
  logic             push;
  logic             pop;

  assign in_ready_o  = (count_r != (AW+1)'(DEPTH)) && !flush_i;  // Full at DEPTH words
  assign out_valid_o = (count_r != '0);
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i && !flush_i;
  assign out_data_o  = mem_r[rptr_r];
  assign count_o     = count_r;

  // Storage
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_r[wptr_r] <= in_data_i;
    end
  end

  // Pointers and level
  always_ff @(posedge clk_i) begin
    if (reset_i || flush_i) begin
      wptr_r  <= '0;
      rptr_r  <= '0;
      count_r <= '0;
    end else begin
      if (push) wptr_r <= wptr_r + AW'(1);
      if (pop)  rptr_r <= rptr_r + AW'(1);
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule : hfq_stage

`default_nettype wire

// ---- rtl/hfq_top.sv ----
// Host queue, watermark alerts and interrupt request registers
`timescale 1ns/1ps
`default_nettype none
`include "hfq_params.svh"

// Overview of operation
// - Size select one gives 255 byte capacity, zero gives 512 bytes.
// - High alert is one when capacity minus fill is at most threshold.
// - Low alert is one when fill is at most threshold.
// - Flush bit empties queue and zeroes fill; it always reads zero.
// - Control bit 2 is threshold bit 8, used only in 512 byte mode.
// - Control bits 1:0 show fill bits 9:8, used only in 512 mode.
// - Fill count resets to zero, counts up on writes, down on reads.
// - Data port accesses do not advance the host address pointer.
// - Port is off over UART, read/write over I2C, read only over SPI.
// - Status write bit 7 picks set or clear for lower bits written one.
// - Watermark flags latch on alert and stay until cleared by host.
// - Idle flag sets on self return to idle, not on host idle command.
// - Transmit flag sets once the last outgoing bit is sent.
// - Receive flag sets at end of incoming stream, good or bad.
// - Error flag sets on any of five listed queue or link faults.
// - Frame start flag sets on start of frame or subcarrier.
// - Second status write touches bits 5:0 only, never the global bit.
// - Global flag is set while any enabled status flag is set.
// - Timers set bits 4:0 on underflow; card detect sets bit 5.
// - Each enable bit gates its flag into the global flag.
// - Invert bit 7 of first enable register flips pin polarity.
// - Global flag reaches the pin only while pin enable bit 6 is one.
// - Second enable bit 7 one is push-pull, zero is open-drain.
// - Writes to a full queue set overflow and are dropped.

module hfq_top #(
  parameter int QDEPTH = 512,
  parameter int SDEPTH = 8
) (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              reset_i,
  // Host register port
  input  wire hfq_pkg::hfq_req_s req_i,
  input  wire hfq_pkg::hfq_link_e link_i,
  output logic [7:0]             rdata_o,
  output logic                   rvalid_o,
  output logic                   addr_inc_o,
  // Engine events
  input  wire hfq_pkg::hfq_evt_s evt_i,
  // Fault level to the error register
  output logic                   queue_overflow_fault_o,
  // Interrupt pin
  output logic                   irq_pin_o,
  output logic                   irq_pin_oe_o
);

  // ************************************************************
  // Register state
  // ************************************************************
  logic       size_sel_r;
  logic       thr8_r;
  logic [7:0] thresh_r;
  logic [6:0] stat_a_r;
  logic [5:0] stat_b_r;
  logic [7:0] mask_a_r;
  logic [7:0] mask_b_r;
  logic       ovf_r;
  logic       any_intr;
  logic       high_watermark_flag;
  logic       low_watermark_flag;
  logic       flush;
  logic [9:0] cap;
  logic [9:0] fill_count;
  logic [8:0] thr_eff;
  logic [3:0] stage_cnt;

  wire wr = req_i.wr;
  wire rd = req_i.rd;
  wire [6:0] addr = req_i.addr;
  wire [7:0] wd = req_i.wdata;

  // Port permission by host link type
  wire port_rd_ok = (link_i == hfq_pkg::HFQ_LINK_I2C) ||
                    (link_i == hfq_pkg::HFQ_LINK_SPI);
  wire port_wr_ok = (link_i == hfq_pkg::HFQ_LINK_I2C);
  wire port_wr = wr && addr == `HFQ_ADDR_PORT && port_wr_ok;
  wire port_rd = rd && addr == `HFQ_ADDR_PORT && port_rd_ok;

  // ************************************************************
  // Queue and output buffer
  // ************************************************************
  assign flush = wr && addr == `HFQ_ADDR_CTRL && wd[`HFQ_CTRL_FLUSH_BIT];
  assign cap = size_sel_r ? `HFQ_CAP_SMALL : `HFQ_CAP_LARGE;

  logic       q_in_ready;
  logic       q_out_valid;
  logic [7:0] q_out_data;
  logic [9:0] q_count;
  logic       s_in_ready;
  logic       s_out_valid;
  logic [7:0] s_out_data;

  hfq_fifo #(.WIDTH(8), .DEPTH(QDEPTH), .CW(10)) u_queue (
    .clk_i       (clk_i),
    .reset_i     (reset_i),
    .flush_i     (flush),
    .cap_i       (cap - 10'(stage_cnt)),
    .in_valid_i  (port_wr),
    .in_ready_o  (q_in_ready),
    .in_data_i   (wd),
    .out_valid_o (q_out_valid),
    .out_ready_i (s_in_ready),
    .out_data_o  (q_out_data),
    .count_o     (q_count)
  );

  // Prefetch buffer so a read answers next cycle from a register
  hfq_stage #(.WIDTH(8), .DEPTH(SDEPTH)) u_stage (
    .clk_i       (clk_i),
    .reset_i     (reset_i),
    .flush_i     (flush),
    .in_valid_i  (q_out_valid),
    .in_ready_o  (s_in_ready),
    .in_data_i   (q_out_data),
    .out_valid_o (s_out_valid),
    .out_ready_i (port_rd),
    .out_data_o  (s_out_data),
    .count_o     (stage_cnt)
  );

  // Bytes held anywhere count toward the host-visible level
  assign fill_count = q_count + 10'(stage_cnt);
  assign thr_eff = {thr8_r & ~size_sel_r, thresh_r};
  assign high_watermark_flag = (cap - fill_count) <= 10'(thr_eff);
  assign low_watermark_flag  = fill_count <= 10'(thr_eff);

  // Overflow fault: full-queue writes dropped, fault latched until flush
  always_ff @(posedge clk_i) begin
    if (reset_i || flush) begin
      ovf_r <= 1'b0;
    end else if (port_wr && !q_in_ready) begin
      ovf_r <= 1'b1;
    end
  end

  // ************************************************************
  // Control registers
  // ************************************************************
  // Size select is taken as written; host empties first
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      size_sel_r <= 1'b0;
      thr8_r     <= 1'b0;
    end else if (wr && addr == `HFQ_ADDR_CTRL) begin
      size_sel_r <= wd[`HFQ_CTRL_SIZE_BIT];
      thr8_r     <= wd[`HFQ_CTRL_THR8_BIT];
    end
  end

  // Threshold and enable masks
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      thresh_r <= `HFQ_RST_BYTE;
      mask_a_r <= `HFQ_RST_BYTE;
      mask_b_r <= `HFQ_RST_BYTE;
    end else if (wr) begin
      if (addr == `HFQ_ADDR_THRESH) thresh_r <= wd;
      if (addr == `HFQ_ADDR_MASK_A) mask_a_r <= wd;
      if (addr == `HFQ_ADDR_MASK_B) mask_b_r <= wd;
    end
  end

  // ************************************************************
  // Interrupt status
  // ************************************************************
  logic [6:0] ev_a;
  logic [5:0] ev_b;
  logic       hi_q_r;
  logic       lo_q_r;

  // Alert edge detect so a held alert is not re-latched after clear
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      hi_q_r <= 1'b0;
      lo_q_r <= 1'b1;  // Low alert is true straight after reset; no false edge
    end else begin
      hi_q_r <= high_watermark_flag;
      lo_q_r <= low_watermark_flag;
    end
  end

  always_comb begin
    ev_a[6] = high_watermark_flag && !hi_q_r;
    ev_a[5] = low_watermark_flag && !lo_q_r;
    ev_a[4] = evt_i.cmd_self_idle;
    ev_a[3] = evt_i.send_done;
    ev_a[2] = evt_i.recv_end;
    ev_a[1] = evt_i.queue_write_fault || (port_wr && !q_in_ready) ||
              evt_i.protocol_fault || evt_i.empty_send_fault ||
              evt_i.integrity_fault;
    ev_a[0] = evt_i.frame_start;
    ev_b    = {evt_i.card_detect, evt_i.tmr_underflow};
  end

  // Set-or-clear write; hardware events win over a clear
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      stat_a_r <= 7'h00;
    end else begin
      if (wr && addr == `HFQ_ADDR_STAT_A) begin
        if (wd[`HFQ_SETCLR_BIT]) stat_a_r <= stat_a_r | wd[6:0] | ev_a;
        else stat_a_r <= (stat_a_r & ~wd[6:0]) | ev_a;
      end else begin
        stat_a_r <= stat_a_r | ev_a;
      end
    end
  end

  // Second status: host reaches bits 5:0 only
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      stat_b_r <= 6'h00;
    end else begin
      if (wr && addr == `HFQ_ADDR_STAT_B) begin
        if (wd[`HFQ_SETCLR_BIT]) stat_b_r <= stat_b_r | (wd[5:0] & `HFQ_STAT_B_MASK) | ev_b;
        else stat_b_r <= (stat_b_r & ~(wd[5:0] & `HFQ_STAT_B_MASK)) | ev_b;
      end else begin
        stat_b_r <= stat_b_r | ev_b;
      end
    end
  end

  // Global flag derived live from flags and enables
  assign any_intr = |(stat_a_r & mask_a_r[6:0]) | |(stat_b_r & mask_b_r[5:0]);

  // Pin level ahead of the output flops
  logic pin_lvl;
  assign pin_lvl = (any_intr && mask_b_r[`HFQ_PIN_GATE_BIT]) ^
                   mask_a_r[`HFQ_INV_BIT];

  // Pin drive, registered; open-drain only drives the pin while its level is low
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      irq_pin_o    <= 1'b0;
      irq_pin_oe_o <= 1'b0;
    end else begin
      irq_pin_o    <= pin_lvl;
      irq_pin_oe_o <= mask_b_r[`HFQ_PUSH_PULL_BIT] || !pin_lvl;
    end
  end

  // ************************************************************
  // Read path
  // ************************************************************
  logic [7:0] rmux;
  always_comb begin
    rmux = `HFQ_RST_BYTE;
    case (addr)
      `HFQ_ADDR_CTRL:   rmux = {size_sel_r, high_watermark_flag, low_watermark_flag,
                                1'b0, 1'b0, thr8_r, fill_count[9:8]};
      `HFQ_ADDR_THRESH: rmux = thresh_r;
      `HFQ_ADDR_FILL:   rmux = fill_count[7:0];
      `HFQ_ADDR_PORT:   rmux = (port_rd && s_out_valid) ? s_out_data : `HFQ_RST_BYTE;
      `HFQ_ADDR_STAT_A: rmux = {1'b0, stat_a_r};
      `HFQ_ADDR_STAT_B: rmux = {1'b0, any_intr, stat_b_r};
      `HFQ_ADDR_MASK_A: rmux = mask_a_r;
      `HFQ_ADDR_MASK_B: rmux = mask_b_r;
      default:          rmux = `HFQ_RST_BYTE;
    endcase
  end

  // Registered answer and address-advance hint
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rdata_o                <= `HFQ_RST_BYTE;
      rvalid_o               <= 1'b0;
      addr_inc_o             <= 1'b0;
      queue_overflow_fault_o <= 1'b0;
    end else begin
      rdata_o                <= rd ? rmux : rdata_o;
      rvalid_o               <= rd;
      addr_inc_o             <= (rd || wr) && addr != `HFQ_ADDR_PORT;
      queue_overflow_fault_o <= ovf_r || (port_wr && !q_in_ready);
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  chk_fill_incr: assert property (@(posedge clk_i) disable iff (reset_i)
    port_wr && q_in_ready && !flush && !port_rd |=> fill_count == $past(fill_count) + 10'd1)
    else $error("fill did not rise on port write");
  chk_flush_zero: assert property (@(posedge clk_i) disable iff (reset_i)
    flush |=> fill_count == 10'd0) else $error("flush left data");
  chk_cap_limit: assert property (@(posedge clk_i) disable iff (reset_i)
    fill_count <= cap || $past(wr && addr == `HFQ_ADDR_CTRL))
    else $error("fill above capacity");
  chk_low_latch: assert property (@(posedge clk_i) disable iff (reset_i)
    $rose(low_watermark_flag) |=> stat_a_r[5]) else $error("low alert not latched");
  chk_ovf_set: assert property (@(posedge clk_i) disable iff (reset_i)
    port_wr && !q_in_ready && !flush |=> ovf_r && fill_count == $past(fill_count))
    else $error("overflow not flagged");
  chk_stat_clear: assert property (@(posedge clk_i) disable iff (reset_i)
    wr && addr == `HFQ_ADDR_STAT_A && !wd[7] && wd[3] && !ev_a[3] |=> !stat_a_r[3])
    else $error("clear write ignored");
  chk_flag_hold: assert property (@(posedge clk_i) disable iff (reset_i)
    stat_a_r[6] && !(wr && addr == `HFQ_ADDR_STAT_A) |=> stat_a_r[6])
    else $error("flag dropped");
  chk_pin_gate: assert property (@(posedge clk_i) disable iff (reset_i)
    !mask_b_r[6] && !mask_a_r[7] |=> !irq_pin_o) else $error("pin not gated");
  chk_addr_hold: assert property (@(posedge clk_i) disable iff (reset_i)
    rd && addr == `HFQ_ADDR_PORT |=> !addr_inc_o) else $error("pointer advanced");
  // Full-queue high alert, refusals, empty reads, pin style and event latching
  chk_high_alert: assert property (@(posedge clk_i) disable iff (reset_i)
    fill_count == cap |-> high_watermark_flag)
    else $error("high alert missing at full queue");
  chk_port_refuse: assert property (@(posedge clk_i) disable iff (reset_i)
    wr && addr == `HFQ_ADDR_PORT && link_i != hfq_pkg::HFQ_LINK_I2C
    |=> fill_count == $past(fill_count)) else $error("port write taken on wrong link");
  chk_uart_read: assert property (@(posedge clk_i) disable iff (reset_i)
    rd && addr == `HFQ_ADDR_PORT && link_i == hfq_pkg::HFQ_LINK_UART
    |=> rdata_o == `HFQ_RST_BYTE && fill_count == $past(fill_count))
    else $error("port read served over UART");
  chk_empty_read: assert property (@(posedge clk_i) disable iff (reset_i)
    port_rd && fill_count == 10'd0 |=> fill_count == 10'd0 && rdata_o == `HFQ_RST_BYTE)
    else $error("empty read disturbed the queue");
  chk_open_drain: assert property (@(posedge clk_i) disable iff (reset_i)
    !mask_b_r[`HFQ_PUSH_PULL_BIT] |=> !(irq_pin_oe_o && irq_pin_o))
    else $error("open-drain pin driven high");
  chk_stat_a_latch: assert property (@(posedge clk_i) disable iff (reset_i)
    (|ev_a) |=> (stat_a_r & $past(ev_a)) == $past(ev_a))
    else $error("event not latched in first status");
  chk_stat_b_latch: assert property (@(posedge clk_i) disable iff (reset_i)
    (|ev_b) |=> (stat_b_r & $past(ev_b)) == $past(ev_b))
    else $error("event not latched in second status");

  // ************************************************************
  // Coverage
  // ************************************************************
  cov_fill_full: cover property (@(posedge clk_i) fill_count == cap);
  cov_overflow:  cover property (@(posedge clk_i) port_wr && !q_in_ready);
  cov_any_intr:  cover property (@(posedge clk_i) any_intr && irq_pin_oe_o);
  cov_low_latch: cover property (@(posedge clk_i) ev_a[5]);
  cov_refused:   cover property (@(posedge clk_i) wr && addr == `HFQ_ADDR_PORT && !port_wr_ok);

endmodule : hfq_top

`default_nettype wire

// ---- tb/hfq_host.sv ----
// Host controller model driving the register port one byte per access
`timescale 1ns/1ps
`default_nettype none

module hfq_host (
  // Clock
  input  wire logic               clk_i,
  // Register port toward the block
  output var hfq_pkg::hfq_req_s   req_o,
  output var hfq_pkg::hfq_link_e  link_o,
  input  wire logic [7:0]         rdata_i,
  input  wire logic               rvalid_i,
  input  wire logic               addr_inc_i
);
  logic [7:0] rd_q;   // Last byte read
  logic       inc_q;  // Pointer advance of last access
  logic       ok_q;   // Answer seen on time

  // Idle port at time zero
  initial begin
    req_o  = '0;
    link_o = hfq_pkg::HFQ_LINK_I2C;
  end

  // One access; released lines are inverted so stale values never look valid
  task automatic xfer(input logic w, input logic [6:0] a, input logic [7:0] d);
    @(posedge clk_i);
    req_o <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clk_i);
    req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    #1;
    inc_q = addr_inc_i;
    ok_q  = w | rvalid_i;
    rd_q  = rdata_i;
  endtask

  // Link type is a level chosen by the host
  task automatic set_link(input hfq_pkg::hfq_link_e l);
    @(posedge clk_i);
    link_o <= l;
  endtask
endmodule // hfq_host

`default_nettype wire

// ---- tb/host_fifo_and_irq_regs_bench.sv ----
// Self-checking bench of the host queue and interrupt block
`timescale 1ns/1ps
`default_nettype none

module host_fifo_and_irq_regs_bench;
  // Row of the ordinary case table
  typedef struct packed {
    hfq_pkg::hfq_evt_s ev;
    logic [6:0]        wa;
    logic [7:0]        wd;
    logic [6:0]        ra;
    logic [7:0]        m;
    logic [7:0]        x;
  } hfq_row_s;

  logic               clk_i;
  logic               reset_i;
  hfq_pkg::hfq_req_s  req;
  hfq_pkg::hfq_link_e link;
  hfq_pkg::hfq_evt_s  evt_i;
  hfq_pkg::hfq_evt_s  e;
  logic [7:0]         rdata_o;
  logic               rvalid_o;
  logic               addr_inc_o;
  logic               queue_overflow_fault_o;
  logic               irq_pin_o;
  logic               irq_pin_oe_o;
  int                 err_total;
  int                 checked;
  hfq_row_s           rows[$];

  hfq_top #(.QDEPTH(512), .SDEPTH(8)) i_hfq_top (
    .clk_i(clk_i), .reset_i(reset_i), .req_i(req), .link_i(link), .rdata_o(rdata_o),
    .rvalid_o(rvalid_o), .addr_inc_o(addr_inc_o), .evt_i(evt_i),
    .queue_overflow_fault_o(queue_overflow_fault_o), .irq_pin_o(irq_pin_o),
    .irq_pin_oe_o(irq_pin_oe_o));

  hfq_host i_hfq_host (
    .clk_i(clk_i), .req_o(req), .link_o(link), .rdata_i(rdata_o), .rvalid_i(rvalid_o),
    .addr_inc_i(addr_inc_o));

  // Clock at 200 MHz
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] x);
    checked++;
    if (s !== x) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", n, x, s);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    i_hfq_host.xfer(1'b1, a, d);
  endtask

  // Read, then compare masked byte plus the answer flag
  task automatic rdchk(input string n, input logic [6:0] a, input logic [7:0] m,
                       input logic [7:0] x);
    i_hfq_host.xfer(1'b0, a, 8'h00);
    chk(n, {i_hfq_host.ok_q, i_hfq_host.rd_q & m}, {1'b1, x});
  endtask

  task automatic fillq(input int n);
    for (int k = 0; k < n; k++) begin
      wr(7'h05, 8'(k + 1));
    end
  endtask

  task automatic add(input hfq_pkg::hfq_evt_s v, input logic [6:0] wa, input logic [7:0] wd,
                     input logic [6:0] ra, input logic [7:0] m, input logic [7:0] x);
    rows.push_back('{ev: v, wa: wa, wd: wd, ra: ra, m: m, x: x});
  endtask

  // Pin level and drive enable two edges after the masks settle
  task automatic pin(input logic [7:0] ma, input logic [7:0] mb, input logic [1:0] x);
    wr(7'h08, ma);
    wr(7'h09, mb);
    repeat (2) @(posedge clk_i);
    #1;
    chk("pin", {irq_pin_o, irq_pin_oe_o}, x);
  endtask

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Hang guard, far beyond the 1,400 or so cycles the tests need
  initial begin
    #200000;
    err_total++;
    wrap_up();
  end

  // Main sequence
  initial begin
    err_total = 0;
    checked   = 0;
    reset_i   = 1'b1;
    evt_i     = '0;
    e         = '0;
    add(e, 7'h03, 8'ha5, 7'h03, 8'hff, 8'ha5);
    add(e, 7'h08, 8'h3c, 7'h08, 8'hff, 8'h3c);
    add(e, 7'h09, 8'h03, 7'h09, 8'hff, 8'h03);
    add(e, 7'h02, 8'h10, 7'h02, 8'h10, 8'h00);
    add(e, 7'h06, 8'hff, 7'h06, 8'h7f, 8'h7f);
    add(e, 7'h06, 8'h0f, 7'h06, 8'h7f, 8'h70);
    add(e, 7'h07, 8'hff, 7'h07, 8'h3f, 8'h3f);
    add(e, 7'h07, 8'h7f, 7'h07, 8'h7f, 8'h40);
    add(e, 7'h08, 8'h00, 7'h07, 8'h40, 8'h00);
    // One row per engine event; the four fault bits all go to the error flag, other bits to their own
    for (int k = 0; k < 14; k++) begin
      e    = '0;
      e[k] = 1'b1;
      if (k < 6) add(e, 7'h00, 8'h00, 7'h07, 8'h3f, 8'h01 << (k ? k - 1 : 5));
      else if (k < 10) add(e, 7'h00, 8'h00, 7'h06, 8'h1f, 8'h02);
      else add(e, 7'h00, 8'h00, 7'h06, 8'h1f, 8'h01 << ((k == 10) ? 0 : k - 9));
    end
    repeat (3) @(posedge clk_i);
    reset_i <= 1'b0;
    rdchk("fill_rst", 7'h04, 8'hff, 8'h00);
    rdchk("stat_rst", 7'h06, 8'h7f, 8'h00);
    foreach (rows[i]) begin
      if (rows[i].ev != '0) begin
        wr(7'h06, 8'h7f);
        wr(7'h07, 8'h3f);
        @(posedge clk_i);
        evt_i <= rows[i].ev;
        @(posedge clk_i);
        evt_i <= '0;
      end
      if (rows[i].wa != 7'h00) wr(rows[i].wa, rows[i].wd);
      rdchk("row", rows[i].ra, rows[i].m, rows[i].x);
    end
    $display("test table done");
    wr(7'h06, 8'h7f);
    wr(7'h06, 8'h81);
    pin(8'h01, 8'h40, 2'b10);
    pin(8'h81, 8'h40, 2'b01);
    pin(8'h01, 8'hc0, 2'b11);
    pin(8'h01, 8'h80, 2'b01);
    pin(8'h00, 8'hc0, 2'b01);
    $display("test pin done");
    // Stream through the port, then refusals per link type
    wr(7'h02, 8'h10);
    fillq(3);
    chk("inc_port", i_hfq_host.inc_q, 1'b0);
    rdchk("fill3", 7'h04, 8'hff, 8'h03);
    chk("inc_reg", i_hfq_host.inc_q, 1'b1);
    for (int k = 0; k < 3; k++) rdchk("data", 7'h05, 8'hff, 8'(k + 1));
    rdchk("fill0", 7'h04, 8'hff, 8'h00);
    rdchk("empty", 7'h05, 8'hff, 8'h00);
    rdchk("fill_e", 7'h04, 8'hff, 8'h00);
    i_hfq_host.set_link(hfq_pkg::HFQ_LINK_SPI);
    wr(7'h05, 8'h44);
    rdchk("spi_wr", 7'h04, 8'hff, 8'h00);
    i_hfq_host.set_link(hfq_pkg::HFQ_LINK_I2C);
    wr(7'h05, 8'h55);
    i_hfq_host.set_link(hfq_pkg::HFQ_LINK_UART);
    rdchk("uart_rd", 7'h05, 8'hff, 8'h00);
    rdchk("uart_keep", 7'h04, 8'hff, 8'h01);
    i_hfq_host.set_link(hfq_pkg::HFQ_LINK_SPI);
    rdchk("spi_rd", 7'h05, 8'hff, 8'h55);
    i_hfq_host.set_link(hfq_pkg::HFQ_LINK_I2C);
    $display("test port done");
    // Small queue filled past its top; size changed only once emptied
    wr(7'h02, 8'h10);
    wr(7'h02, 8'h80);
    wr(7'h03, 8'h00);
    fillq(256);
    rdchk("fill255", 7'h04, 8'hff, 8'hff);
    chk("ovf", queue_overflow_fault_o, 1'b1);
    rdchk("high", 7'h02, 8'h40, 8'h40);
    rdchk("keep", 7'h05, 8'hff, 8'h01);
    rdchk("err_irq", 7'h06, 8'h02, 8'h02);
    wr(7'h02, 8'h90);
    rdchk("flushed", 7'h04, 8'hff, 8'h00);
    chk("ovf_clr", queue_overflow_fault_o, 1'b0);
    $display("test small done");
    // Large queue beyond 256 bytes with the ninth threshold bit
    wr(7'h02, 8'h00);
    fillq(300);
    rdchk("fill_lo", 7'h04, 8'hff, 8'h2c);
    rdchk("fill_hi", 7'h02, 8'h03, 8'h01);
    wr(7'h03, 8'h2c);
    wr(7'h02, 8'h04);
    rdchk("thr9", 7'h02, 8'h67, 8'h65);
    wr(7'h02, 8'h00);
    rdchk("thr8", 7'h02, 8'h67, 8'h01);
    wr(7'h06, 8'h7f);
    wr(7'h02, 8'h10);
    rdchk("low_latch", 7'h06, 8'h20, 8'h20);
    $display("test large done");
    // Reset in mid-run with bytes held and a low alert latched
    fillq(2);
    @(posedge clk_i);
    reset_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    reset_i <= 1'b0;
    rdchk("fill_rst2", 7'h04, 8'hff, 8'h00);
    rdchk("stat_rst2", 7'h06, 8'h7f, 8'h00);
    chk("pin_rst2", {irq_pin_o, irq_pin_oe_o}, 2'b01);
    $display("test reset done");
    wrap_up();
  end
endmodule // host_fifo_and_irq_regs_bench

`default_nettype wire
